// ===== cache_maint_defs.vh
// Constants for the cache maintenance command block.
// Included by the design files; definitions only.
`ifndef CACHE_MAINT_DEFS_VH
`define CACHE_MAINT_DEFS_VH
`define CM_SETS          1024
`define CM_IDX_W         10
`define CM_TAG_W         18
`define CM_WORD_W        32
`define CM_SET_CMD_HI    27
`define CM_SET_CMD_LO    24
`define CM_LINE_CMD_HI   27
`define CM_LINE_CMD_LO   24
`define CM_RES_HI        22
`define CM_RES_LO        20
`define CM_OP_SEARCH     2'h0
`define CM_OP_INVAL      2'h1
`define CM_OP_PUSH       2'h2
`define CM_OP_CLEAR      2'h3
`define CM_PA_IDX_HI     13
`define CM_PA_IDX_LO     4
`define CM_PA_TAG_HI     31
`define CM_PA_TAG_LO     14
`define CM_LINE_WORDS    3'h4
`endif

// ===== cache_tag_way.v
// One way of tag state: 1024 entries of tag, valid and modified bits.
// Assumes a single clock, synchronous reset only clears valid and modified.
`timescale 1ns/100ps
`default_nettype none
`include "cache_maint_defs.vh"
module cache_tag_way (
  input  wire                    clock_i,
  input  wire                    reset_i,
  input  wire                    clk_en_i,
  input  wire [`CM_IDX_W-1:0]    idx_i,
  input  wire                    wr_tag_i,
  input  wire [`CM_TAG_W-1:0]    tag_i,
  input  wire                    wr_flags_i,
  input  wire                    valid_i,
  input  wire                    mod_i,
  output wire [`CM_TAG_W-1:0]    tag_o,
  output wire                    valid_o,
  output wire                    mod_o
);
  reg [`CM_TAG_W-1:0] tag_q [0:`CM_SETS-1];
  reg [`CM_SETS-1:0]  valid_q;
  reg [`CM_SETS-1:0]  mod_q;

  // Combinational read, flops are small enough for a model of the array
  assign tag_o   = tag_q[idx_i];
  assign valid_o = valid_q[idx_i];
  assign mod_o   = mod_q[idx_i];

  // Tag storage needs no reset; software must invalidate before use
  always @(posedge clock_i) begin
    if (clk_en_i && wr_tag_i) begin
      tag_q[idx_i] <= tag_i;
    end
  end

  // Flag storage, cleared so simulation starts from a known state
  always @(posedge clock_i) begin
    if (reset_i) begin
      valid_q <= {`CM_SETS{1'b0}};
      mod_q   <= {`CM_SETS{1'b0}};
    end else if (clk_en_i && wr_flags_i) begin
      valid_q[idx_i] <= valid_i;
      mod_q[idx_i]   <= mod_i;
    end
  end
endmodule // cache_tag_way
`default_nettype wire

// ===== cache_maint.v
// Cache maintenance engine: set commands and single-line commands on a
// two-way tag store with a word-addressed data array held in flops.
// Assumes registers are plain ports driven by synchronous logic.
`timescale 1ns/100ps
`default_nettype none
`include "cache_maint_defs.vh"
// Operation
// - All four set bits set: clear both ways, pushing modified lines.
// - Line command acts on one line; cache mode uses index and way.
// - Physical mode looks up both ways at address 13:4, acts on hit.
// - Line commands run regardless of the cache enable control.
// - Line go starts command, reads one while busy, cleared at end.
// - Line go is shared by line command and search address registers.
// - Field decodes as access flag, address kind and two-bit op.
// - Access flag, cache mode, op 00 writes value; other access codes nop.
// - Tag-or-data pick selects tag entry or data word for value.
// - Result bits 22:20 give way, modified and valid at completion.
// - Result captured before action; physical miss reports valid zero.
// - Valid zero means no line operation was performed.
// - Value register holds initial tag or data after non-write commands.
// - Bit 23 carries no result meaning.
// - Two ways of 1024 sets, 16-byte lines, tag plus valid, modified.
// - Invalidate clears valid and modified without write-back.
// - Push writes back valid modified lines; clear also drops valid.
// - Set go starts set command and stays set until done.
module cache_maint (
  input  wire                   clock_i,
  input  wire                   reset_i,
  input  wire                   clk_en_i,
  input  wire                   cache_on_i,
  input  wire [3:0]             set_cmd_i,
  input  wire                   set_go_i,
  output wire                   set_busy_o,
  input  wire [3:0]             line_cmd_i,
  input  wire                   way_pick_i,
  input  wire                   tag_or_data_pick_i,
  input  wire [11:0]            cache_line_index_i,
  input  wire                   line_cmd_wr_i,
  input  wire [31:0]            physical_target_address_i,
  input  wire                   search_addr_wr_i,
  input  wire                   line_go_i,
  output wire                   line_go_o,
  input  wire [31:0]            rw_value_i,
  input  wire                   rw_value_wr_i,
  output reg  [31:0]            rw_value_o,
  output reg                    result_way_o,
  output reg                    result_modified_o,
  output reg                    result_valid_o,
  output wire                   result_reserved_o,
  output reg                    wb_valid_o,
  output reg  [31:0]            wb_addr_o,
  output reg  [31:0]            wb_data_o,
  input  wire                   wb_ready_i
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_LOOK = 3'h1;
  localparam [2:0] ST_ACT  = 3'h2;
  localparam [2:0] ST_WB   = 3'h3;
  localparam [2:0] ST_UPD  = 3'h4;

  reg [2:0]           state_q;
  reg                 set_mode_q;
  reg [3:0]           set_cmd_q;
  reg [3:0]           cmd_q;
  reg                 tdp_q;
  reg                 way_q;
  reg [11:0]          cidx_q;
  reg [31:0]          pa_q;
  reg [`CM_IDX_W-1:0] set_q;
  reg                 cur_way_q;
  reg [1:0]           cur_op_q;
  reg [2:0]           wcnt_q;
  reg [`CM_TAG_W-1:0] wb_tag_q;
  reg [31:0]          data_q [0:4*`CM_SETS*2-1];

  wire busy = (state_q != ST_IDLE);
  assign set_busy_o        = busy & set_mode_q;
  assign line_go_o         = busy & ~set_mode_q;
  assign result_reserved_o = 1'b0;

  // Way array instances
  wire [`CM_IDX_W-1:0] idx = set_mode_q ? set_q :
    (cmd_q[2] ? pa_q[`CM_PA_IDX_HI:`CM_PA_IDX_LO] : cidx_q[11:2]);
  wire [`CM_TAG_W-1:0] tag_rd [0:1];
  wire [1:0] val_rd;
  wire [1:0] mod_rd;
  reg  [1:0] wr_tag;
  reg  [1:0] wr_flags;
  reg        nv_valid;
  reg        nv_mod;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_way
      cache_tag_way u_way (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .clk_en_i  (clk_en_i),
        .idx_i     (idx),
        .wr_tag_i  (wr_tag[g]),
        .tag_i     (rw_value_o[`CM_PA_TAG_HI:`CM_PA_TAG_LO]),
        .wr_flags_i(wr_flags[g]),
        .valid_i   (nv_valid),
        .mod_i     (nv_mod),
        .tag_o     (tag_rd[g]),
        .valid_o   (val_rd[g]),
        .mod_o     (mod_rd[g])
      );
    end
  endgenerate

  // Physical lookup in both ways
  wire [`CM_TAG_W-1:0] pa_tag = pa_q[`CM_PA_TAG_HI:`CM_PA_TAG_LO];
  wire hit0 = val_rd[0] & (tag_rd[0] == pa_tag);
  wire hit1 = val_rd[1] & (tag_rd[1] == pa_tag);
  wire cw   = cur_way_q;
  wire cur_v = val_rd[cw];
  wire cur_m = mod_rd[cw];

  // Data word index: way, set, word
  function [12:0] dix;
    input w;
    input [`CM_IDX_W-1:0] s;
    input [1:0] wd;
    begin
      dix = {w, s, wd};
    end
  endfunction

  // Set command per way: push bit and invalidate bit form the op
  function [1:0] way_op;
    input [3:0] c;
    input w;
    begin
      way_op = w ? {c[3], c[2]} : {c[1], c[0]};
    end
  endfunction

  // Flag update for the current op, and tag writes from the value register
  always @* begin
    wr_tag   = 2'b00;
    wr_flags = 2'b00;
    nv_valid = 1'b0;
    nv_mod   = 1'b0;
    if (state_q == ST_UPD) begin
      wr_flags[cw] = 1'b1;
      nv_valid = (cur_op_q == `CM_OP_PUSH) ? cur_v : 1'b0;
      nv_mod   = 1'b0;
    end else if (state_q == ST_ACT && !set_mode_q && cmd_q[3] && !cmd_q[2]
                 && cmd_q[1:0] == `CM_OP_SEARCH && !tdp_q) begin
      // Tag write seeds the flags too: value bit 0 valid, bit 1 modified
      wr_tag[cw]   = 1'b1;
      wr_flags[cw] = 1'b1;
      nv_valid     = rw_value_o[0];
      nv_mod       = rw_value_o[1];
    end
  end

  // Main sequencer; cache_on_i is deliberately unused here
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE; set_mode_q <= 1'b0; set_cmd_q <= 4'h0;
      cmd_q <= 4'h0; tdp_q <= 1'b0; way_q <= 1'b0; cidx_q <= 12'h000;
      pa_q <= 32'h00000000; set_q <= {`CM_IDX_W{1'b0}}; cur_way_q <= 1'b0;
      cur_op_q <= 2'h0; wcnt_q <= 3'h0; wb_tag_q <= {`CM_TAG_W{1'b0}};
      rw_value_o <= 32'h00000000; result_way_o <= 1'b0;
      result_modified_o <= 1'b0; result_valid_o <= 1'b0;
      wb_valid_o <= 1'b0; wb_addr_o <= 32'h00000000; wb_data_o <= 32'h00000000;
    end else if (clk_en_i) begin
      case (state_q)
        ST_IDLE: begin
          // Register loads only while idle, so a busy command is untouched
          if (rw_value_wr_i) rw_value_o <= rw_value_i;
          if (line_cmd_wr_i) begin
            cmd_q <= line_cmd_i; way_q <= way_pick_i;
            tdp_q <= tag_or_data_pick_i; cidx_q <= cache_line_index_i;
          end
          if (search_addr_wr_i) pa_q <= physical_target_address_i;
          if (set_go_i && set_cmd_i != 4'h0) begin
            set_mode_q <= 1'b1; set_cmd_q <= set_cmd_i; set_q <= {`CM_IDX_W{1'b0}};
            // Skip way 0 when only way 1 has work, else its flags get cleared
            cur_way_q <= (way_op(set_cmd_i, 1'b0) == 2'h0);
            cur_op_q <= (way_op(set_cmd_i, 1'b0) == 2'h0) ? way_op(set_cmd_i, 1'b1)
                        : way_op(set_cmd_i, 1'b0);
            state_q <= ST_ACT;
          end else if (line_go_i && (line_cmd_wr_i || search_addr_wr_i)) begin
            set_mode_q <= 1'b0;
            state_q <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          cur_op_q <= cmd_q[1:0];
          if (cmd_q[3]) begin
            cur_way_q <= way_q;
            state_q <= (cmd_q[2] || cmd_q[1:0] != `CM_OP_SEARCH) ? ST_IDLE : ST_ACT;
          end else if (cmd_q[2]) begin
            cur_way_q <= hit1;
            result_way_o <= hit1; result_valid_o <= hit0 | hit1;
            result_modified_o <= hit1 ? mod_rd[1] : mod_rd[0];
            state_q <= ST_ACT;
          end else begin
            cur_way_q <= way_q;
            result_way_o <= way_q; result_valid_o <= val_rd[way_q];
            result_modified_o <= mod_rd[way_q];
            state_q <= ST_ACT;
          end
        end
        ST_ACT: begin
          wb_tag_q <= tag_rd[cw];
          wcnt_q <= 3'h0;
          if (!set_mode_q && cmd_q[3]) begin
            if (tdp_q) data_q[dix(cw, idx, cidx_q[1:0])] <= rw_value_o;
            state_q <= ST_IDLE;
          end else begin
            if (!set_mode_q)
              rw_value_o <= tdp_q ? data_q[dix(cw, idx, cmd_q[2] ? pa_q[3:2] : cidx_q[1:0])]
                : {tag_rd[cw], idx, 4'h0};
            // Result valid is the hit on physical commands, so a miss never acts
            if (!set_mode_q && (!result_valid_o || cur_op_q == `CM_OP_SEARCH))
              state_q <= ST_IDLE;
            else if (cur_op_q == 2'h0) state_q <= ST_UPD;
            else if (cur_v && cur_m && cur_op_q[1]) state_q <= ST_WB;
            else if (cur_op_q[0] || cur_v) state_q <= ST_UPD;
            else state_q <= ST_UPD;
          end
        end
        ST_WB: begin
          // One word per accepted beat; the line finishes before go drops
          wb_valid_o <= 1'b1;
          wb_addr_o <= {wb_tag_q, idx, wcnt_q[1:0], 2'h0};
          wb_data_o <= data_q[dix(cw, idx, wcnt_q[1:0])];
          if (wb_valid_o && wb_ready_i) begin
            if (wcnt_q == `CM_LINE_WORDS - 3'h1) begin
              wb_valid_o <= 1'b0; state_q <= ST_UPD;
            end else begin
              wcnt_q <= wcnt_q + 3'h1;
              wb_addr_o <= {wb_tag_q, idx, wcnt_q[1:0] + 2'h1, 2'h0};
              wb_data_o <= data_q[dix(cw, idx, wcnt_q[1:0] + 2'h1)];
            end
          end
        end
        default: begin // ST_UPD
          if (!set_mode_q) state_q <= ST_IDLE;
          else if (cur_way_q == 1'b0 && way_op(set_cmd_q, 1'b1) != 2'h0) begin
            cur_way_q <= 1'b1; cur_op_q <= way_op(set_cmd_q, 1'b1); state_q <= ST_ACT;
          end else if (set_q == `CM_SETS - 1) begin
            state_q <= ST_IDLE;
          end else begin
            set_q <= set_q + 10'h001; state_q <= ST_ACT;
            cur_way_q <= (way_op(set_cmd_q, 1'b0) == 2'h0);
            cur_op_q <= (way_op(set_cmd_q, 1'b0) == 2'h0) ? way_op(set_cmd_q, 1'b1)
                        : way_op(set_cmd_q, 1'b0);
          end
        end
      endcase
    end
  end
endmodule // cache_maint
`default_nettype wire

// ===== cache_maint_props.sv
// Port-level assertions for the cache maintenance engine.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cache_maint_chk (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       clk_en_i,
  input wire logic [3:0] set_cmd_i,
  input wire logic       set_go_i,
  input wire logic       set_busy_o,
  input wire logic       line_cmd_wr_i,
  input wire logic       search_addr_wr_i,
  input wire logic       line_go_i,
  input wire logic       line_go_o,
  input wire logic       result_way_o,
  input wire logic       result_modified_o,
  input wire logic       result_valid_o,
  input wire logic       result_reserved_o,
  input wire logic       wb_valid_o,
  input wire logic       wb_ready_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic idle;
  logic wb_seen_q;
  assign idle = clk_en_i && !set_busy_o && !line_go_o;
  // Remembers a write-back beat inside the running line command
  always @(posedge clock_i) begin
    if (reset_i || (idle && line_go_i)) wb_seen_q <= 1'b0;
    else if (wb_valid_o && line_go_o) wb_seen_q <= 1'b1;
  end
  a_reserved_zero: assert property (result_reserved_o == 1'b0)
    else $error("reserved result bit set");
  a_set_start: assert property (idle && set_go_i && |set_cmd_i |=> set_busy_o)
    else $error("set command not started");
  a_line_start: assert property (idle && line_go_i && (line_cmd_wr_i || search_addr_wr_i)
    && !(set_go_i && |set_cmd_i) |=> line_go_o) else $error("line command not started");
  a_one_busy: assert property (!(set_busy_o && line_go_o))
    else $error("two commands running at once");
  a_refuse_set: assert property (line_go_o && set_go_i |=> !set_busy_o)
    else $error("set command taken while line busy");
  a_wb_in_busy: assert property (wb_valid_o |-> (set_busy_o || line_go_o))
    else $error("write-back outside a command");
  a_wb_held: assert property (wb_valid_o && !wb_ready_i |=> wb_valid_o)
    else $error("write-back dropped before accepted");
  a_invalid_no_wb: assert property ($fell(line_go_o) && !result_valid_o |-> !wb_seen_q)
    else $error("write-back on an invalid line");
  a_result_hold: assert property (!line_go_o && $past(!line_go_o)
    |-> $stable({result_way_o, result_modified_o, result_valid_o}))
    else $error("result changed while idle");
  c_line: cover property ($fell(line_go_o));
  c_set: cover property ($fell(set_busy_o));
  c_refused: cover property (line_go_o && set_go_i);
  c_wb_beat: cover property (wb_valid_o && wb_ready_i);
endmodule // cache_maint_chk
bind cache_maint cache_maint_chk i_cache_maint_chk (.*);
`default_nettype wire

// ===== test_cache_maint.sv
// Self-checking bench for the cache maintenance engine.
// Assumes the bound checker file is compiled before it.
`timescale 1ns/100ps
`default_nettype none
module test_cache_maint;
  logic        clock_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, cache_on_i = 1'b0;
  logic [3:0]  set_cmd_i = 4'h0, line_cmd_i = 4'h0;
  logic        set_go_i = 1'b0, way_pick_i = 1'b0, tag_or_data_pick_i = 1'b0;
  logic [11:0] cache_line_index_i = 12'h000;
  logic        line_cmd_wr_i = 1'b0, search_addr_wr_i = 1'b0, line_go_i = 1'b0;
  logic [31:0] physical_target_address_i = 32'h0, rw_value_i = 32'h0;
  logic        rw_value_wr_i = 1'b0, wb_ready_i = 1'b1;
  logic        set_busy_o, line_go_o, result_way_o, result_modified_o;
  logic        result_valid_o, result_reserved_o, wb_valid_o;
  logic [31:0] rw_value_o, wb_addr_o, wb_data_o;
  int          failures = 0, checked = 0, cycles = 0, wb_beats = 0;
  cache_maint i_cache_maint (.*);
  // 8 ns clock
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  // Beat counter and hang guard; full sweeps dominate the run time
  always @(posedge clock_i) begin
    cycles++;
    if (wb_valid_o === 1'b1 && wb_ready_i) wb_beats++;
    if (cycles == 60000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic err(input string m);
    failures++;
    $display("ERROR %0t: %s", $time, m);
  endtask
  task automatic chk_bit(input logic a, e, input string m);
    checked++;
    if (a !== e) err(m);
  endtask
  task automatic chk_res(input logic [2:0] e, input string m);
    checked++;
    if ({result_way_o, result_modified_o, result_valid_o} !== e) err(m);
  endtask
  task automatic chk_word(input logic [31:0] a, e, input string m);
    checked++;
    if (a !== e) err(m);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((line_go_o !== 1'b0 || set_busy_o !== 1'b0) && n < 30000) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 30000) err("command hung");
  endtask
  task automatic value(input logic [31:0] v);
    rw_value_i = v;
    rw_value_wr_i = 1'b1;
    @(negedge clock_i);
    rw_value_wr_i = 1'b0;
  endtask
  task automatic set_run(input logic [3:0] c);
    set_cmd_i = c;
    set_go_i = 1'b1;
    @(negedge clock_i);
    set_go_i = 1'b0;
    chk_bit(set_busy_o, |c, "set busy wrong");
    wait_idle();
  endtask
  // Physical non-access kinds load fields first, then search address with go
  task automatic line(input logic [3:0] c, input logic w, td, input logic [11:0] ix,
                      input logic [31:0] pa);
    line_cmd_i = c;
    way_pick_i = w;
    tag_or_data_pick_i = td;
    cache_line_index_i = ix;
    physical_target_address_i = pa;
    line_cmd_wr_i = 1'b1;
    line_go_i = (c[3:2] != 2'b01);
    @(negedge clock_i);
    line_cmd_wr_i = 1'b0;
    if (c[3:2] == 2'b01) begin
      search_addr_wr_i = 1'b1;
      line_go_i = 1'b1;
      @(negedge clock_i);
      search_addr_wr_i = 1'b0;
    end
    line_go_i = 1'b0;
    chk_bit(line_go_o, 1'b1, "line go not busy");
    wait_idle();
  endtask
  initial begin
    repeat (8) @(negedge clock_i);
    reset_i = 1'b0;
    set_run(4'h0);
    set_run(4'h5);
    set_run(4'hf);
    chk_word(wb_beats, 32'h0, "write-back of invalid lines");
    line(4'h0, 1'b0, 1'b1, 12'h005, 32'h0);
    chk_res(3'b000, "way 0 result");
    line(4'h0, 1'b1, 1'b1, 12'h005, 32'h0);
    chk_res(3'b100, "way 1 result");
    value(32'hcafe_0001);
    line(4'h8, 1'b1, 1'b1, 12'h008, 32'h0);
    value(32'h1234_5678);
    line(4'h8, 1'b1, 1'b1, 12'h009, 32'h0);
    value(32'habcd_c000);
    line(4'h8, 1'b1, 1'b0, 12'h008, 32'h0);
    line(4'h0, 1'b1, 1'b0, 12'h008, 32'h0);
    chk_word({rw_value_o[31:14], 14'h0}, 32'habcd_c000, "tag readback");
    cache_on_i = 1'b1;
    line(4'h0, 1'b1, 1'b1, 12'h009, 32'h0);
    chk_word(rw_value_o, 32'h1234_5678, "word 1 readback");
    cache_on_i = 1'b0;
    for (int c = 9; c < 16; c++) begin
      value(32'hdead_beef);
      line(c[3:0], 1'b1, 1'b1, 12'h008, 32'h0);
    end
    line(4'h0, 1'b1, 1'b1, 12'h008, 32'h0);
    chk_word(rw_value_o, 32'hcafe_0001, "reserved code wrote");
    // Set request arrives while a line command is busy
    fork
      line(4'h0, 1'b1, 1'b1, 12'h009, 32'h0);
      begin
        @(negedge clock_i);
        set_cmd_i = 4'h5;
        set_go_i = 1'b1;
        @(negedge clock_i);
        set_go_i = 1'b0;
        chk_bit(set_busy_o, 1'b0, "set taken while busy");
      end
    join
    chk_word(rw_value_o, 32'h1234_5678, "search after refusal");
    for (int c = 0; c < 8; c++) begin
      line(c[3:0], 1'b0, 1'b1, 12'h00c, 32'h0000_0030);
      chk_bit(result_valid_o, 1'b0, "hit on invalid line");
    end
    chk_word(wb_beats, 32'h0, "write-back of clean lines");
    // Seed a valid modified line in way 0, set 3, then reach it by physical address
    for (int k = 0; k < 4; k++) begin
      value(32'h5a5a_0000 + k);
      line(4'h8, 1'b0, 1'b1, 12'h00c + k[11:0], 32'h0);
    end
    value(32'h0000_4003);
    line(4'h8, 1'b0, 1'b0, 12'h00c, 32'h0);
    line(4'h4, 1'b0, 1'b1, 12'h000, 32'h0000_4034);
    chk_res(3'b011, "physical hit result");
    chk_word(rw_value_o, 32'h5a5a_0001, "physical data read");
    // Push with the sink stalled for a few cycles
    wb_ready_i = 1'b0;
    fork
      line(4'h6, 1'b0, 1'b1, 12'h000, 32'h0000_4030);
      begin
        repeat (6) @(negedge clock_i);
        wb_ready_i = 1'b1;
      end
    join
    chk_word(wb_beats, 32'h4, "push beat count");
    chk_word(wb_addr_o, 32'h0000_403c, "last write-back address");
    chk_word(wb_data_o, 32'h5a5a_0003, "last write-back word");
    chk_res(3'b011, "push result");
    line(4'h4, 1'b0, 1'b1, 12'h000, 32'h0000_4030);
    chk_res(3'b001, "modified not cleared");
    set_run(4'h8);
    line(4'h7, 1'b0, 1'b1, 12'h000, 32'h0000_8030);
    chk_bit(result_valid_o, 1'b0, "miss reported valid");
    line(4'h5, 1'b0, 1'b1, 12'h000, 32'h0000_4030);
    chk_res(3'b001, "line lost before invalidate");
    line(4'h4, 1'b0, 1'b1, 12'h000, 32'h0000_4030);
    chk_res(3'b000, "invalidate left line valid");
    chk_word(wb_beats, 32'h4, "write-back without modified line");
    wrap_up();
  end
endmodule // test_cache_maint
`default_nettype wire
